/* File: shared/jtag_port_pkg.sv */
// constants and types shared by the scan and emulation port
`default_nettype none
package jtag_port_pkg;

  // instruction register
  localparam int unsigned IR_W = 4;
  localparam logic [3:0] IR_CAPTURE  = 4'h1;
  localparam logic [3:0] IR_RESET    = 4'h1;
  localparam logic [3:0] OP_IDCODE   = 4'h1;
  localparam logic [3:0] OP_EMU_CTRL = 4'h8;
  localparam logic [3:0] OP_BYPASS   = 4'hF;

  // identity register
  localparam int unsigned ID_W = 32;

  // emulation control register: [1:0] pin direction (1 = out), [3:2] pin drive level
  localparam int unsigned EMU_PINS  = 2;
  localparam int unsigned EMU_W     = 4;
  localparam int unsigned EMU_DIR_LSB = 0;
  localparam int unsigned EMU_LVL_LSB = 2;
  localparam logic [3:0] EMU_RESET  = 4'h0;

  // synchroniser width: number of pin inputs sampled
  localparam int unsigned SYNC_W = 6;

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET,
    RUN_TEST_IDLE,
    SELECT_DR,
    CAPTURE_DR,
    SHIFT_DR,
    EXIT1_DR,
    PAUSE_DR,
    EXIT2_DR,
    UPDATE_DR,
    SELECT_IR,
    CAPTURE_IR,
    SHIFT_IR,
    EXIT1_IR,
    PAUSE_IR,
    EXIT2_IR,
    UPDATE_IR
  } tap_state_t;

endpackage
`default_nettype wire

/* File: verilog/tap_sequencer.sv */
// sixteen-state test access port sequencer
`timescale 1ns/100ps
`default_nettype none
module tap_sequencer
  import jtag_port_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       scan_reset_i,
  input  wire logic       tck_rise_i,
  input  wire logic       tms_i,
  output var  tap_state_t state_o
);

  tap_state_t next_state;

  always_comb begin
    next_state = state_o;
    case (state_o)
      TEST_LOGIC_RESET: next_state = tms_i ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
      RUN_TEST_IDLE:    next_state = tms_i ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_DR:        next_state = tms_i ? SELECT_IR : CAPTURE_DR;
      CAPTURE_DR:       next_state = tms_i ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR:         next_state = tms_i ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR:         next_state = tms_i ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR:         next_state = tms_i ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR:         next_state = tms_i ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR:        next_state = tms_i ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_IR:        next_state = tms_i ? TEST_LOGIC_RESET : CAPTURE_IR;
      CAPTURE_IR:       next_state = tms_i ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR:         next_state = tms_i ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR:         next_state = tms_i ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR:         next_state = tms_i ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR:         next_state = tms_i ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR:        next_state = tms_i ? SELECT_DR : RUN_TEST_IDLE;
      default:          next_state = TEST_LOGIC_RESET;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_o <= TEST_LOGIC_RESET;
    end else if (scan_reset_i) begin
      state_o <= TEST_LOGIC_RESET; // RQ5
    end else if (tck_rise_i) begin
      state_o <= next_state; // RQ3
    end
  end

endmodule
`default_nettype wire

/* File: verilog/jtag_scan_emulation_port.sv */
// scan test and emulation port: tap, scan registers, event pins, crystal drive gating
//
// How it works
// RQ1 - test data in is taken into the selected scan register on test clock rise
// RQ2 - selected scan register shifts out on test data out at test clock fall
// RQ3 - tap sequencer samples mode select on each test clock rise
// RQ4 - test reset high hands device control to the scan system
// RQ5 - test reset low: functional mode, scan logic held reset and ignored
// RQ6 - with test reset high, event pins are emulator interrupts, direction set by scan
// RQ7 - crystal drive output floats while emulator pin 1 is held low
// RQ8 - standard sixteen-state tap; instruction selects the data register on the chain
`timescale 1ns/100ps
`default_nettype none
module jtag_scan_emulation_port
  import jtag_port_pkg::*;
#(
  parameter logic [31:0] ID_CODE = 32'h1234_5001 // arbitrary value
) (
  input  wire logic                ref_clk_i,
  input  wire logic                nrst_i,
  // test port pins
  input  wire logic                tck_i,
  input  wire logic                tms_i,
  input  wire logic                tdi_i,
  input  wire logic                trst_i,
  output logic                     tdo_o,
  output logic                     tdo_oe_o,
  // emulator event pins, split into input, output and enable
  input  wire logic                emulator_event_pin_0_i,
  output logic                     emulator_event_pin_0_o,
  output logic                     emulator_event_pin_0_oe_o,
  input  wire logic                emulator_event_pin_1_i,
  output logic                     emulator_event_pin_1_o,
  output logic                     emulator_event_pin_1_oe_o,
  // core side
  input  wire logic [EMU_PINS-1:0] core_event_i,
  output logic      [EMU_PINS-1:0] emulator_event_o,
  output logic                     scan_control_o,
  // oscillator drive
  input  wire logic                osc_drive_i,
  output logic                     crystal_drive_output_o,
  output logic                     crystal_drive_output_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic              rst_n_s1;
  logic              rst_n;
  logic [SYNC_W-1:0] pin_s1;
  logic [SYNC_W-1:0] pin_s2;
  logic              tck_d;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_n_s1 <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_n_s1 <= 1'b1;
      rst_n    <= rst_n_s1;
    end
  end

  // first stage is read only by the second stage
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 6'h00;
      pin_s2 <= 6'h00;
      tck_d  <= 1'b0;
    end else begin
      pin_s1 <= {emulator_event_pin_1_i, emulator_event_pin_0_i,
                 trst_i, tdi_i, tms_i, tck_i};
      pin_s2 <= pin_s1;
      tck_d  <= pin_s2[0];
    end
  end

  wire                tck_s     = pin_s2[0];
  wire                tms_s     = pin_s2[1];
  wire                tdi_s     = pin_s2[2];
  wire                trst_s    = pin_s2[3];
  wire [EMU_PINS-1:0] emu_pin_s = pin_s2[5:4];
  // tms and tdi share the tck latency, so edges see matching data
  wire                tck_rise  = tck_s & ~tck_d;
  wire                tck_fall  = ~tck_s & tck_d;
  wire                scan_reset = ~trst_s; // RQ5

  ////////////////////////////////////////////////////////////////////////////
  // tap sequencer

  tap_state_t state;

  tap_sequencer u_tap (
    .ref_clk_i    (ref_clk_i),
    .rst_n_i      (rst_n),
    .scan_reset_i (scan_reset),
    .tck_rise_i   (tck_rise),
    .tms_i        (tms_s),
    .state_o      (state)
  ); // RQ8

  wire step       = tck_rise & ~scan_reset;
  wire capture_ir = step & (state == CAPTURE_IR);
  wire shift_ir   = step & (state == SHIFT_IR);
  wire update_ir  = step & (state == UPDATE_IR);
  wire capture_dr = step & (state == CAPTURE_DR);
  wire shift_dr   = step & (state == SHIFT_DR);
  wire update_dr  = step & (state == UPDATE_DR);
  wire in_shift   = (state == SHIFT_IR) | (state == SHIFT_DR);

  ////////////////////////////////////////////////////////////////////////////
  // instruction register

  logic [IR_W-1:0] ir_sr;
  logic [IR_W-1:0] ir;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ir_sr <= IR_RESET;
      ir    <= OP_IDCODE;
    end else if (scan_reset || (step && state == TEST_LOGIC_RESET)) begin
      ir_sr <= IR_RESET;
      ir    <= OP_IDCODE;
    end else begin
      if (capture_ir) begin
        ir_sr <= IR_CAPTURE;
      end else if (shift_ir) begin
        ir_sr <= {tdi_s, ir_sr[IR_W-1:1]}; // RQ1
      end
      if (update_ir) begin
        ir <= ir_sr;
      end
    end
  end

  // unknown instructions fall back to bypass
  wire sel_id  = (ir == OP_IDCODE); // RQ8
  wire sel_emu = (ir == OP_EMU_CTRL); // RQ8

  ////////////////////////////////////////////////////////////////////////////
  // data registers

  logic              bypass_sr;
  logic [ID_W-1:0]   id_sr;
  logic [EMU_W-1:0]  emu_sr;
  logic [EMU_W-1:0]  emu_ctl;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bypass_sr <= 1'b0;
      id_sr     <= 32'h0000_0000;
      emu_sr    <= EMU_RESET;
    end else if (capture_dr) begin
      bypass_sr <= 1'b0;
      id_sr     <= ID_CODE;
      // capture shows pin levels in the level field so the emulator sees events
      emu_sr    <= {emu_pin_s, emu_ctl[EMU_DIR_LSB +: EMU_PINS]};
    end else if (shift_dr) begin
      bypass_sr <= tdi_s; // RQ1
      if (sel_id) begin
        id_sr <= {tdi_s, id_sr[ID_W-1:1]}; // RQ1
      end
      if (sel_emu) begin
        emu_sr <= {tdi_s, emu_sr[EMU_W-1:1]}; // RQ1
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      emu_ctl <= EMU_RESET;
    end else if (scan_reset) begin
      emu_ctl <= EMU_RESET; // RQ5
    end else if (update_dr && sel_emu) begin
      emu_ctl <= emu_sr; // RQ6
    end
  end

  wire dr_bit   = sel_id ? id_sr[0] : (sel_emu ? emu_sr[0] : bypass_sr);
  wire scan_bit = (state == SHIFT_IR) ? ir_sr[0] : dr_bit;

  ////////////////////////////////////////////////////////////////////////////
  // test data out, changed only on the test clock fall, cleared while scan reset is held

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (scan_reset) begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (tck_fall) begin
      tdo_o    <= scan_bit; // RQ2
      tdo_oe_o <= in_shift; // RQ2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // emulator event pins

  logic [EMU_PINS-1:0] pin_out;
  logic [EMU_PINS-1:0] pin_oe;

  genvar g;
  generate
    for (g = 0; g < EMU_PINS; g++) begin : g_emu
      wire dir_out = emu_ctl[EMU_DIR_LSB + g];
      wire lvl     = emu_ctl[EMU_LVL_LSB + g];
      always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          pin_out[g]          <= 1'b1;
          pin_oe[g]           <= 1'b0;
          emulator_event_o[g] <= 1'b0;
        end else begin
          // pins idle undriven in functional mode
          pin_out[g]          <= lvl & core_event_i[g]; // RQ6
          pin_oe[g]           <= trst_s & dir_out; // RQ6
          // active-low event from the emulator, only while scan owns the device
          emulator_event_o[g] <= trst_s & ~dir_out & ~emu_pin_s[g]; // RQ6
        end
      end
    end
  endgenerate

  assign emulator_event_pin_0_o    = pin_out[0];
  assign emulator_event_pin_0_oe_o = pin_oe[0];
  assign emulator_event_pin_1_o    = pin_out[1];
  assign emulator_event_pin_1_oe_o = pin_oe[1];

  ////////////////////////////////////////////////////////////////////////////
  // scan control handover and crystal drive gating

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      scan_control_o            <= 1'b0;
      crystal_drive_output_o    <= 1'b0;
      crystal_drive_output_oe_o <= 1'b0;
    end else begin
      scan_control_o            <= trst_s; // RQ4
      crystal_drive_output_o    <= osc_drive_i;
      // the pin level counts, whoever pulls it low
      crystal_drive_output_oe_o <= emu_pin_s[1]; // RQ7
    end
  end

endmodule
`default_nettype wire

/* File: test/jtag_port_properties.sv */
// port checker for the scan and emulation block
`timescale 1ns/100ps
`default_nettype none
module jtag_port_properties
  import jtag_port_pkg::*;
(
  input wire logic                ref_clk_i,
  input wire logic                nrst_i,
  input wire logic                tck_i,
  input wire logic                trst_i,
  input wire logic                tdo_o,
  input wire logic                tdo_oe_o,
  input wire logic                emulator_event_pin_0_o,
  input wire logic                emulator_event_pin_0_oe_o,
  input wire logic                emulator_event_pin_1_i,
  input wire logic                emulator_event_pin_1_oe_o,
  input wire logic [EMU_PINS-1:0] core_event_i,
  input wire logic [EMU_PINS-1:0] emulator_event_o,
  input wire logic                scan_control_o,
  input wire logic                crystal_drive_output_oe_o
);
  // cycles since release; the pin synchronisers hold stale levels early on
  logic [2:0] up;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  xtal_float_a: assert property (
    (up == 3'h7 && !emulator_event_pin_1_i) [*6] |=> !crystal_drive_output_oe_o)
    else $error("crystal drive not floated");
  xtal_drive_a: assert property (
    (up == 3'h7 && emulator_event_pin_1_i) [*6] |=> crystal_drive_output_oe_o)
    else $error("crystal drive not enabled");
  scan_idle_a: assert property (
    (!trst_i) [*6] |=> !scan_control_o && !tdo_oe_o && !emulator_event_pin_0_oe_o
    && !emulator_event_pin_1_oe_o && emulator_event_o == 2'h0)
    else $error("scan logic active with test reset low");
  ctrl_take_a: assert property (
    (up == 3'h7 && trst_i) [*6] |=> scan_control_o)
    else $error("scan control not taken");
  tdo_edge_a: assert property (
    trst_i && $past(trst_i, 6) && $changed(tdo_o) |-> !$past(tck_i))
    else $error("test data out moved after a rising test clock");
  shift_own_a: assert property (
    tdo_oe_o |-> scan_control_o)
    else $error("test data out driven without scan control");
  pin_own_a: assert property (
    emulator_event_pin_0_oe_o || emulator_event_pin_1_oe_o |-> scan_control_o)
    else $error("event pin driven without scan control");
  pin_level_a: assert property (
    up == 3'h7 && !$past(core_event_i[0]) |-> !emulator_event_pin_0_o)
    else $error("event pin 0 high without core event");
  evt_core_a: assert property (
    emulator_event_o[1] |-> scan_control_o && !emulator_event_pin_1_oe_o)
    else $error("event to core from a driven or idle pin");
  cover property (tdo_oe_o);
  cover property (emulator_event_pin_0_oe_o && emulator_event_pin_0_o);
  cover property (emulator_event_o[1]);
endmodule
`default_nettype wire

/* File: test/scan_emulator.sv */
// emulator model driving the test port pins
`timescale 1ns/100ps
`default_nettype none
module scan_emulator (
  input  wire logic clk_i,
  input  wire logic tdo_i,
  output var  logic tck_o,
  output var  logic tms_o,
  output var  logic tdi_o,
  output var  logic trst_o
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    trst_o = 1'b0;
  end
  task automatic take(input logic v);
    trst_o = v;
  endtask
  task automatic half();
    repeat (4) @(posedge clk_i);
    #1;
  endtask
  // lsb first; test clock rests low between calls
  task automatic step(input int n, input logic [31:0] ms, di, output logic [31:0] q);
    q = 32'h0000_0000;
    for (int i = 0; i < n; i++) begin
      tms_o = ms[i];
      tdi_o = di[i];
      half();
      tck_o = 1'b1;
      half();
      q[i] = tdo_i;
      tck_o = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// self-checking bench for the scan and emulation port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import jtag_port_pkg::*;
  localparam logic [31:0] ID = 32'h5A3C_0F01; // arbitrary value
  logic        clk, nrst, tck, tms, tdi, trst, tdo, tdo_oe, p0_o, p0_oe, p1_o, p1_oe;
  logic        drv1, ctl, osc, x_o, x_oe;
  logic [1:0]  core_ev, emu_ev;
  logic [31:0] q;
  int          n_mismatch = 0;
  int          num_checks = 0;
  // pull-down on test data out, pull-up on event pin 0, pin 1 driven by drv1 when released
  wire logic   tdo_w = tdo_oe ? tdo : 1'b0;
  wire logic   pin0 = p0_oe ? p0_o : 1'b1;
  wire logic   pin1 = p1_oe ? p1_o : drv1;
  jtag_scan_emulation_port #(.ID_CODE(ID)) i_dut (
    .ref_clk_i(clk), .nrst_i(nrst), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .trst_i(trst), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .emulator_event_pin_0_i(pin0), .emulator_event_pin_0_o(p0_o),
    .emulator_event_pin_0_oe_o(p0_oe), .emulator_event_pin_1_i(pin1),
    .emulator_event_pin_1_o(p1_o), .emulator_event_pin_1_oe_o(p1_oe),
    .core_event_i(core_ev), .emulator_event_o(emu_ev), .scan_control_o(ctl),
    .osc_drive_i(osc), .crystal_drive_output_o(x_o), .crystal_drive_output_oe_o(x_oe)
  );
  scan_emulator u_emu (
    .clk_i(clk), .tdo_i(tdo_w), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_o(trst)
  );
  task automatic chk(input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // from run-test-idle through shift to update and back to idle
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
                      output logic [31:0] dout);
    logic [31:0] d;
    u_emu.step(ir ? 4 : 3, ir ? 32'h0000_0003 : 32'h0000_0001, 32'h0000_0000, d);
    u_emu.step(n, 32'h0000_0001 << (n - 1), din, dout);
    u_emu.step(2, 32'h0000_0001, 32'h0000_0000, d);
  endtask
  task automatic t_idle();
    u_emu.take(1'b0);
    scan(1'b0, 32'hFFFF_FFFF, 32, q);
    chk(q, 32'h0000_0000);
    chk(ctl, 1'b0);
    $display("idle test done");
  endtask
  task automatic t_id();
    u_emu.take(1'b1);
    wt(8);
    chk(ctl, 1'b1);
    u_emu.step(6, 32'h0000_001F, 32'h0000_0000, q);
    scan(1'b0, 32'h0000_0000, 32, q);
    chk(q, ID);
    $display("identity test done");
  endtask
  task automatic t_byp();
    scan(1'b1, {28'h000_0000, OP_BYPASS}, 4, q);
    chk(q[3:0], IR_CAPTURE);
    scan(1'b0, 32'h0000_00B4, 8, q);
    chk(q[7:0], 8'h68);
    // an undecoded instruction must fall back to the one-bit bypass path
    scan(1'b1, 32'h0000_0003, 4, q);
    chk(q[3:0], IR_CAPTURE);
    scan(1'b0, 32'h0000_0001, 2, q);
    chk(q[1:0], 2'h2);
    $display("bypass test done");
  endtask
  task automatic t_emu();
    core_ev = 2'h1;
    scan(1'b1, {28'h000_0000, OP_EMU_CTRL}, 4, q);
    scan(1'b0, 32'h0000_0005, 4, q);
    wt(2);
    chk({p1_oe, p0_oe, p0_o}, 3'h3);
    core_ev = 2'h0;
    wt(2);
    chk(p0_o, 1'b0);
    drv1 = 1'b0;
    wt(8);
    chk(emu_ev, 2'h2);
    chk({x_oe, x_o}, 2'h0);
    core_ev = 2'h1;
    wt(2);
    // turn pin 0 back to input and pin 1 to output with its level bit set, gated by core event 1
    scan(1'b0, 32'h0000_000A, 4, q);
    chk(q[3:0], 4'h5);
    wt(2);
    chk({p1_oe, p0_oe, p1_o}, 3'h4);
    core_ev = 2'h2;
    wt(8);
    chk({p1_o, emu_ev, x_oe}, 4'h9);
    $display("event pin test done");
  endtask
  task automatic t_rst();
    nrst = 1'b0;
    wt(2);
    chk({ctl, tdo, p1_oe, p0_o, p1_o, x_oe}, 6'h06);
    nrst = 1'b1;
    wt(8);
    chk({ctl, p1_oe, emu_ev}, 4'hA);
    $display("reset test done");
  endtask
  task automatic t_rel();
    drv1 = 1'b1;
    osc = 1'b1;
    u_emu.take(1'b0);
    wt(8);
    chk({ctl, p1_oe, p0_oe, x_oe, x_o}, 5'h03);
    $display("release test done");
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    nrst = 1'b0;
    core_ev = 2'h0;
    drv1 = 1'b1;
    osc = 1'b0;
    wt(12);
    nrst = 1'b1;
    wt(8);
    t_idle();
    t_id();
    t_byp();
    t_emu();
    t_rst();
    t_rel();
    summarize();
  end
  // a hang counts as a mismatch
  initial begin
    #2000000;
    n_mismatch++;
    summarize();
  end
endmodule
bind jtag_scan_emulation_port jtag_port_properties i_chk (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .tck_i(tck_i), .trst_i(trst_i),
  .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
  .emulator_event_pin_0_o(emulator_event_pin_0_o),
  .emulator_event_pin_0_oe_o(emulator_event_pin_0_oe_o),
  .emulator_event_pin_1_i(emulator_event_pin_1_i),
  .emulator_event_pin_1_oe_o(emulator_event_pin_1_oe_o),
  .core_event_i(core_event_i), .emulator_event_o(emulator_event_o),
  .scan_control_o(scan_control_o), .crystal_drive_output_oe_o(crystal_drive_output_oe_o)
);
`default_nettype wire
